// ==== core/power_context_trim_commands.sv ====
/*
 * Command interpreter for regulator selection, context store/restore
 * across sleep and crystal load trim, fed by the SPI pins and by bytes
 * from a UART receiver on sys_clk.
 * Assumes SCK is well below sys_clk/4 and SPI mode 0, MSB first.
 */
`include "power_ctx_defs.svh"
module power_context_trim_commands
  import power_ctx_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Host links
  input wire spi_pins_in_t spi_in,
  output spi_pins_out_t spi_out,
  input wire uart_byte_t uart_in,
  // Operation controls
  input wire logic duty_cycle_en,
  input wire logic rx_ptr_advance,
  // Status
  output logic busy,
  output radio_mode_t radio_mode,
  output regulator_sel_t regulator,
  output logic [4:0] crystal_load_steps,
  output logic [7:0] rx_payload_ptr
);

  ctrl_state_t st_reg;
  ctrl_state_t st_next;

  // Commands that carry no parameter bytes
  function automatic logic no_param(input logic [7:0] op);
    no_param = (op == `OP_STORE_CONTEXT) || (op == `OP_FREQ_SYNTH) ||
               (op == `OP_RECEIVE) || (op == `OP_TRANSMIT);
  endfunction

  function automatic logic [7:0] reg_read(input ctrl_state_t s, input logic [15:0] a);
    reg_read = 8'h00;
    if (a == `ADDR_TRIM_FIRST) begin
      reg_read = s.trim_first;
    end else if (a == `ADDR_TRIM_SECOND) begin
      reg_read = s.trim_second;
    end
  endfunction

  // Act on one byte of a command; pidx 0 is the opcode itself
  function automatic ctrl_state_t take_byte(input ctrl_state_t s, input logic [7:0] op,
                                            input logic [2:0] pidx, input logic [7:0] b,
                                            input logic duty);
    ctrl_state_t r;
    r = s;
    unique case (op)
      `OP_SELECT_REGULATOR: begin
        if (pidx == 3'd1 && b <= 8'h01) begin
          r.regulator_choice = b[0];
        end
      end
      `OP_STORE_CONTEXT: begin
        if (pidx == 3'd0) begin
          r.ram_trim_first = s.trim_first;
          r.ram_trim_second = s.trim_second;
          r.ram_dump_valid = 1'b1;
        end
      end
      `OP_ENTER_SLEEP: begin
        if (pidx == 3'd1) begin
          r.mode = mode_sleep;
          r.ram_retained = b[`SLEEP_RETAIN_BIT];
          if (duty) begin
            r.ram_trim_first = s.trim_first;
            r.ram_trim_second = s.trim_second;
            r.ram_dump_valid = 1'b1;
            r.ram_retained = 1'b1;
          end else if (!b[`SLEEP_RETAIN_BIT]) begin
            r.ram_dump_valid = 1'b0;
          end
          r.trim_first = `TRIM_RESET;
          r.trim_second = `TRIM_RESET;
        end
      end
      `OP_STANDBY: begin
        if (pidx == 3'd1) begin
          r.mode = b[`STANDBY_XOSC_BIT] ? standby_crystal : standby_rc_osc;
        end
      end
      `OP_FREQ_SYNTH: r.mode = freq_synth_mode;
      `OP_RECEIVE: r.mode = mode_receive;
      `OP_TRANSMIT: r.mode = mode_transmit;
      `OP_REGISTER_WRITE, `OP_REGISTER_READ: begin
        if (pidx == 3'd1) begin
          r.addr = {b, s.addr[7:0]};
        end else if (pidx == 3'd2) begin
          r.addr = {s.addr[15:8], b};
        end else if (pidx >= 3'd3 && op == `OP_REGISTER_WRITE) begin
          if (s.addr == `ADDR_TRIM_FIRST) begin
            r.trim_first = b;
          end
          if (s.addr == `ADDR_TRIM_SECOND) begin
            r.trim_second = b;
          end
          r.addr = s.addr + 16'h0001;
        end
      end
      default: r = s;
    endcase
    take_byte = r;
  endfunction

  always_comb begin
    logic sck_rise;
    logic sck_fall;
    logic nss_fall;
    logic [7:0] byte_in;
    logic [2:0] pidx;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    nss_fall = 1'b0;
    byte_in = 8'h00;
    pidx = 3'd0;
    st_next = st_reg;
    st_next.nss_s1 = spi_in.nss_n;
    st_next.nss_s2 = st_reg.nss_s1;
    st_next.nss_s3 = st_reg.nss_s2;
    st_next.sck_s1 = spi_in.sck;
    st_next.sck_s2 = st_reg.sck_s1;
    st_next.sck_s3 = st_reg.sck_s2;
    st_next.mosi_s1 = spi_in.mosi;
    st_next.mosi_s2 = st_reg.mosi_s1;
    sck_rise = st_reg.sck_s2 && !st_reg.sck_s3;
    sck_fall = !st_reg.sck_s2 && st_reg.sck_s3;
    nss_fall = !st_reg.nss_s2 && st_reg.nss_s3;

    if (rx_ptr_advance) begin
      st_next.rx_ptr = st_reg.rx_ptr + 8'h01;
    end

    if (st_reg.mode == mode_sleep) begin
      // Wake on select; only bits clocked before the wake are discarded, the rest of the frame is decoded
      st_next.bit_cnt = 3'd0;
      st_next.spi_idx = 3'd0;
      st_next.uart_idx = 3'd0;
      if (nss_fall) begin
        st_next.mode = standby_rc_osc;
        if (st_reg.ram_retained && st_reg.ram_dump_valid) begin
          st_next.trim_first = st_reg.ram_trim_first;
          st_next.trim_second = st_reg.ram_trim_second;
        end
        if (duty_cycle_en) begin
          st_next.rx_ptr = `RX_PTR_RESET;
        end
      end
    end else begin
      if (st_reg.nss_s2) begin
        st_next.bit_cnt = 3'd0;
        st_next.spi_idx = 3'd0;
        st_next.tx_shift = 8'h00;
      end else begin
        // A byte loaded on the last rise keeps its first bit past the next fall
        if (sck_fall && st_reg.bit_cnt != 3'd0) begin
          st_next.tx_shift = {st_reg.tx_shift[6:0], 1'b0};
        end
        if (sck_rise) begin
          byte_in = {st_reg.rx_shift[6:0], st_reg.mosi_s2};
          st_next.rx_shift = byte_in;
          st_next.bit_cnt = st_reg.bit_cnt + 3'd1;
          if (st_reg.bit_cnt == 3'd7) begin
            if (st_reg.spi_idx == 3'd0) begin
              st_next.spi_op = byte_in;
            end
            st_next = take_byte(st_next, (st_reg.spi_idx == 3'd0) ? byte_in : st_reg.spi_op,
                                st_reg.spi_idx, byte_in, duty_cycle_en);
            if (st_reg.spi_op == `OP_REGISTER_READ && st_reg.spi_idx >= 3'd2 &&
                st_reg.spi_idx != 3'd0) begin
              st_next.tx_shift = reg_read(st_reg, st_next.addr);
              st_next.addr = st_next.addr + 16'h0001;
            end
            if (st_reg.spi_idx != 3'd7) begin
              st_next.spi_idx = st_reg.spi_idx + 3'd1;
            end
          end
        end
      end

      if (uart_in.valid && st_next.mode != mode_sleep) begin
        unique case (st_reg.uart_idx)
          3'd0: begin
            st_next.uart_op = uart_in.data;
            if (no_param(uart_in.data)) begin
              st_next = take_byte(st_next, uart_in.data, 3'd0, uart_in.data,
                                  duty_cycle_en);
            end else begin
              st_next.uart_idx = 3'd1;
            end
          end
          3'd1: begin
            st_next.uart_len = uart_in.data;
            if (st_reg.uart_op == `OP_SELECT_REGULATOR &&
                uart_in.data != `UART_REG_SELECT_LEN) begin
              st_next.uart_idx = 3'd0;
            end else begin
              st_next.uart_idx = (uart_in.data == 8'h00) ? 3'd0 : 3'd2;
            end
          end
          default: begin
            pidx = st_reg.uart_idx - 3'd1;
            st_next = take_byte(st_next, st_reg.uart_op, pidx, uart_in.data,
                                duty_cycle_en);
            if ({5'h00, pidx} >= st_reg.uart_len) begin
              st_next.uart_idx = 3'd0;
            end else if (st_reg.uart_idx != 3'd7) begin
              st_next.uart_idx = st_reg.uart_idx + 3'd1;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.nss_s1 <= 1'b1;
      st_reg.nss_s2 <= 1'b1;
      st_reg.nss_s3 <= 1'b1;
      st_reg.mode <= standby_rc_osc;
      st_reg.regulator_choice <= `REG_CHOICE_LINEAR;
      st_reg.trim_first <= `TRIM_RESET;
      st_reg.trim_second <= `TRIM_RESET;
      st_reg.rx_ptr <= `RX_PTR_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    logic switching_mode;
    switching_mode = (st_reg.mode == standby_crystal) || (st_reg.mode == freq_synth_mode) ||
                     (st_reg.mode == mode_receive) || (st_reg.mode == mode_transmit);
    regulator.dcdc_on = (st_reg.regulator_choice == `REG_CHOICE_SWITCHER) &&
                        switching_mode;
    regulator.ldo_on = !regulator.dcdc_on && (st_reg.mode != mode_sleep);
  end

  assign spi_out.miso_out = st_reg.tx_shift[7];
  assign spi_out.miso_oe = !st_reg.nss_s2 && (st_reg.mode != mode_sleep);
  assign busy = (st_reg.mode == mode_sleep);
  assign radio_mode = st_reg.mode;
  assign crystal_load_steps = st_reg.trim_first[`TRIM_MSB:`TRIM_LSB];
  assign rx_payload_ptr = st_reg.rx_ptr;

endmodule

// ==== shared/power_ctx_defs.svh ====
/*
 * Opcodes, register addresses, reset values and field positions of the
 * regulator, context and crystal trim command block.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef POWER_CTX_DEFS_SVH
`define POWER_CTX_DEFS_SVH

// Opcodes
`define OP_SELECT_REGULATOR 8'h96
`define OP_STORE_CONTEXT 8'hd5
`define OP_ENTER_SLEEP 8'h01
`define OP_STANDBY 8'h02
`define OP_FREQ_SYNTH 8'h03
`define OP_RECEIVE 8'h04
`define OP_TRANSMIT 8'h05
`define OP_REGISTER_WRITE 8'h06
`define OP_REGISTER_READ 8'h07

// UART length byte of the regulator command
`define UART_REG_SELECT_LEN 8'h01

// Regulator choices
`define REG_CHOICE_LINEAR 1'b0
`define REG_CHOICE_SWITCHER 1'b1

// Trim register addresses
`define ADDR_TRIM_FIRST 16'h0a0e
`define ADDR_TRIM_SECOND 16'h0a0f

// Trim field
`define TRIM_LSB 0
`define TRIM_MSB 4
`define TRIM_RESET 8'h00

// Enter-sleep parameter: keep data RAM
`define SLEEP_RETAIN_BIT 0
// Standby parameter: 0 RC oscillator, 1 crystal
`define STANDBY_XOSC_BIT 0

// Receive payload pointer after wake-up
`define RX_PTR_RESET 8'h00

`endif

// ==== shared/power_ctx_pkg.sv ====
/*
 * Types of the regulator, context and crystal trim command block.
 * Assumes power_ctx_defs.svh is on the include path.
 */
package power_ctx_pkg;
  `include "power_ctx_defs.svh"

  typedef enum logic [2:0] {
    mode_sleep,
    standby_rc_osc,
    standby_crystal,
    freq_synth_mode,
    mode_receive,
    mode_transmit
  } radio_mode_t;

  // SPI pins as seen by the device
  typedef struct packed {
    logic nss_n;
    logic sck;
    logic mosi;
  } spi_pins_in_t;

  typedef struct packed {
    logic miso_out;
    logic miso_oe;
  } spi_pins_out_t;

  // Bytes from the UART receiver, same clock
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } uart_byte_t;

  typedef struct packed {
    logic ldo_on;
    logic dcdc_on;
  } regulator_sel_t;

  typedef struct packed {
    logic nss_s1;
    logic nss_s2;
    logic nss_s3;
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic mosi_s1;
    logic mosi_s2;
    logic [2:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic [2:0] spi_idx;
    logic [7:0] spi_op;
    logic [2:0] uart_idx;
    logic [7:0] uart_op;
    logic [7:0] uart_len;
    logic [15:0] addr;
    radio_mode_t mode;
    logic regulator_choice;
    logic [7:0] trim_first;
    logic [7:0] trim_second;
    logic [7:0] ram_trim_first;
    logic [7:0] ram_trim_second;
    logic ram_dump_valid;
    logic ram_retained;
    logic [7:0] rx_ptr;
  } ctrl_state_t;
endpackage

// ==== test/host_spi_model.sv ====
/* Host on the SPI pins: mode 0 frames, MSB first, and wake pulses.
   Assumes sys_clk at 50 MHz; SCK runs at one eighth of it. */
module host_spi_model
  import power_ctx_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // SPI pins
  output spi_pins_in_t pins,
  input wire spi_pins_out_t miso
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_rx = 8'h00;
  initial pins = 3'b100;
  task automatic frame(input logic [7:0] b[$]);
    @(negedge sys_clk);
    pins.nss_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    foreach (b[i]) begin
      for (int k = 7; k >= 0; k--) begin
        pins.mosi = b[i][k];
        repeat (4) @(negedge sys_clk);
        pins.sck = 1'b1;
        last_rx = {last_rx[6:0], miso.miso_out};
        repeat (4) @(negedge sys_clk);
        pins.sck = 1'b0;
      end
    end
    repeat (4) @(negedge sys_clk);
    // Idle: select high, SCK still, MOSI flipped
    pins = {1'b1, 1'b0, ~pins.mosi};
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic wake();
    @(negedge sys_clk);
    pins.nss_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    pins.nss_n = 1'b1;
    repeat (2) @(negedge sys_clk);
  endtask
endmodule

// ==== test/power_context_trim_commands_properties.sv ====
/* Port assertions for the command block.
   Assumes a bind onto power_context_trim_commands. */
module power_context_trim_commands_properties
  import power_ctx_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Inputs
  input wire spi_pins_in_t spi_in,
  input wire uart_byte_t uart_in,
  input wire logic duty_cycle_en,
  // Outputs
  input wire spi_pins_out_t spi_out,
  input wire logic busy,
  input wire radio_mode_t radio_mode,
  input wire regulator_sel_t regulator,
  input wire logic [4:0] crystal_load_steps,
  input wire logic [7:0] rx_payload_ptr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence sel_s(logic c);
    uart_in.valid && uart_in.data == 8'h96 ##1 uart_in.valid && uart_in.data == 8'h01
      ##1 uart_in.valid && uart_in.data == {7'h00, c};
  endsequence
  sequence sw_s;
    sel_s(1'b1) ##0 radio_mode == standby_crystal;
  endsequence
  sequence quiet_s;
    spi_in.nss_n && $past(spi_in.nss_n, 5) && !$past(uart_in.valid) && $stable(radio_mode);
  endsequence
  one_source_a: assert property (!(regulator.ldo_on && regulator.dcdc_on))
    else $error("both regulators on");
  rc_linear_a: assert property (radio_mode == standby_rc_osc |-> regulator == 2'b10)
    else $error("rc standby not on linear");
  uart_linear_a: assert property (sel_s(1'b0) ##0 !busy |=> regulator == 2'b10)
    else $error("uart choice 0 ignored");
  uart_switch_a: assert property (sw_s |=> regulator.dcdc_on)
    else $error("uart choice 1 ignored");
  sleep_drop_a: assert property ($rose(busy) |-> crystal_load_steps == 5'h00)
    else $error("trim kept in sleep");
  wake_ptr_a: assert property ($fell(busy) && duty_cycle_en |-> rx_payload_ptr == 8'h00)
    else $error("payload pointer not zeroed");
  hold_choice_a: assert property (quiet_s |-> $stable(regulator))
    else $error("regulator changed unasked");
  sleep_pins_a: assert property (busy |-> !spi_out.miso_oe)
    else $error("miso driven in sleep");
endmodule

bind power_context_trim_commands power_context_trim_commands_properties props (.sys_clk,
  .rst_n, .spi_in, .uart_in, .duty_cycle_en, .spi_out, .busy, .radio_mode, .regulator,
  .crystal_load_steps, .rx_payload_ptr);

// ==== test/test_power_context_trim_commands.sv ====
/* Self-checking bench for the command block.
   Assumes the host model and the checker are compiled first. */
module test_power_context_trim_commands
  import power_ctx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst_n, duty_cycle_en, rx_ptr_advance, busy;
  spi_pins_in_t spi_in;
  spi_pins_out_t spi_out;
  uart_byte_t uart_in;
  radio_mode_t radio_mode;
  regulator_sel_t regulator;
  logic [4:0] crystal_load_steps;
  logic [7:0] rx_payload_ptr;
  int mismatches = 0;
  int comparisons = 0;
  host_spi_model host (.sys_clk, .pins(spi_in), .miso(spi_out));
  power_context_trim_commands DUT (.sys_clk, .rst_n, .spi_in, .spi_out, .uart_in,
    .duty_cycle_en, .rx_ptr_advance, .busy, .radio_mode, .regulator, .crystal_load_steps,
    .rx_payload_ptr);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_reg(input logic [1:0] e);
    chk("regulator", {6'h00, e}, {6'h00, regulator});
  endtask
  task automatic chk_trim(input logic [4:0] e);
    chk("trim", {3'h0, e}, {3'h0, crystal_load_steps});
  endtask
  task automatic uart(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(negedge sys_clk);
      uart_in = {1'b1, b[i]};
    end
    @(negedge sys_clk);
    uart_in.valid = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic set_trim(input logic [7:0] v);
    host.frame({8'h02, 8'h01});
    host.frame({8'h06, 8'h0a, 8'h0e, v, v});
  endtask
  task automatic sleep_wake(input logic [7:0] p);
    host.frame({8'h01, p});
    chk("busy", 8'h01, {7'h00, busy});
    chk_trim(5'h00);
    host.wake();
    for (int n = 0; n < 64 && busy !== 1'b0; n++) begin
      @(negedge sys_clk);
    end
    if (busy !== 1'b0) begin
      mismatches++;
      $display("MISMATCH wake expected 0 seen %b", busy);
      close_out();
    end
    chk("mode", {5'h00, standby_rc_osc}, {5'h00, radio_mode});
  endtask
  task automatic t_reset();
    chk_reg(2'b10);
    chk_trim(5'h00);
    chk("ptr", 8'h00, rx_payload_ptr);
    $display("done reset");
  endtask
  task automatic t_regulator();
    logic [7:0] ops[3] = '{8'h03, 8'h04, 8'h05};
    set_trim(8'h00);
    host.frame({8'h96, 8'h01});
    chk_reg(2'b01);
    host.frame({8'h96, 8'h02});
    chk_reg(2'b01);
    foreach (ops[i]) begin
      host.frame({ops[i]});
      chk_reg(2'b01);
    end
    host.frame({8'h02, 8'h00});
    chk_reg(2'b10);
    host.frame({8'h02, 8'h01});
    chk_reg(2'b01);
    uart({8'h96, 8'h02, 8'h00, 8'h00});
    chk_reg(2'b01);
    uart({8'h96, 8'h01, 8'h00});
    chk_reg(2'b10);
    uart({8'h96, 8'h01, 8'h01});
    chk_reg(2'b01);
    $display("done regulator");
  endtask
  task automatic t_trim();
    set_trim(8'hf5);
    chk_trim(5'h15);
    host.frame({8'h07, 8'h0a, 8'h0e, 8'h00});
    chk("first", 8'hf5, host.last_rx);
    host.frame({8'h07, 8'h0a, 8'h0f, 8'h00});
    chk("second", 8'hf5, host.last_rx);
    host.frame({8'h07, 8'h0a, 8'h10, 8'h00});
    chk("unmapped", 8'h00, host.last_rx);
    $display("done trim");
  endtask
  task automatic t_context();
    uart({8'hd5});
    sleep_wake(8'h01);
    chk_trim(5'h15);
    sleep_wake(8'h00);
    chk_trim(5'h00);
    set_trim(8'h0a);
    host.frame({8'hd5});
    sleep_wake(8'h01);
    chk_trim(5'h0a);
    $display("done context");
  endtask
  task automatic t_duty();
    duty_cycle_en = 1'b1;
    set_trim(8'h13);
    rx_ptr_advance = 1'b1;
    repeat (3) @(negedge sys_clk);
    rx_ptr_advance = 1'b0;
    @(negedge sys_clk);
    chk("ptr", 8'h03, rx_payload_ptr);
    sleep_wake(8'h00);
    chk("ptr", 8'h00, rx_payload_ptr);
    chk_trim(5'h13);
    duty_cycle_en = 1'b0;
    $display("done duty");
  endtask
  initial begin
    rst_n = 1'b0;
    uart_in = '0;
    duty_cycle_en = 1'b0;
    rx_ptr_advance = 1'b0;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    t_reset();
    t_regulator();
    t_trim();
    t_context();
    t_duty();
    close_out();
  end
endmodule
